// [adc_flag_pkg.sv]
package adc_flag_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h2C;
  localparam logic [7:0] LAST_DATA_OFS = 8'h20;
  localparam logic [7:0] CHAN_DATA_OFS = 8'h30;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int START_BIT = 1;
  localparam int SLEEP_BIT = 5;
  localparam int EOC_POS = 0;
  localparam int OVR_POS = 8;
  localparam int DATA_READY_POS = 16;
  localparam int GOVR_POS = 17;
  localparam int SLEEPING_POS = 18;
  localparam int BUSY_POS = 19;
  // ----------------------------------------------------------------
  // reset values, timing and sizes
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int CONV_CYCLES = 10;
  localparam int NUM_CHANNELS = 8;
  localparam int DATA_WIDTH = 10;
endpackage

// [flag_evt_if.sv]
`timescale 1ns/100ps
interface flag_evt_if #(parameter int N = 8);
  logic status_rd;
  logic last_rd;
  logic [N-1:0] chan_rd;
  logic eoc;
  logic [N-1:0] eoc_chan;
  logic [N-1:0] eoc_flags;
  logic [N-1:0] ovr_flags;
  logic dready;
  logic govr;
  modport ctrl (output status_rd, last_rd, chan_rd, eoc, eoc_chan,
    input eoc_flags, ovr_flags, dready, govr);
  modport flags (input status_rd, last_rd, chan_rd, eoc, eoc_chan,
    output eoc_flags, ovr_flags, dready, govr);
endinterface

// [adc_status_flags.sv]
`timescale 1ns/100ps
module adc_status_flags #(parameter int N = 8) (
  input wire logic core_clk,
  input wire logic rst,
  flag_evt_if.flags f
);
  logic data_ready_flag;
  logic general_overrun_flag;
  logic [N-1:0] eoc_st;
  logic [N-1:0] channel_overrun_flag;
  logic [N-1:0] last_oh;
  logic coincide;
  assign coincide = f.status_rd & f.eoc;
  assign f.dready = data_ready_flag;
  // channel whose result sits in the last data register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_oh <= '0;
    end else if (f.eoc) begin
      last_oh <= f.eoc_chan;
    end
  end
  assign f.govr = general_overrun_flag;
  assign f.eoc_flags = eoc_st;
  assign f.ovr_flags = channel_overrun_flag;
  // ----------------------------------------------------------------
  // data ready
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_ready_flag <= 1'b0;
    end else if (f.eoc) begin
      data_ready_flag <= 1'b1;
    end else if (f.last_rd || (|f.chan_rd)) begin
      data_ready_flag <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // general overrun
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      general_overrun_flag <= 1'b0;
    end else if (coincide) begin
      general_overrun_flag <= general_overrun_flag;
    end else if (f.eoc && data_ready_flag) begin
      general_overrun_flag <= 1'b1;
    end else if (f.status_rd) begin
      general_overrun_flag <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // per-channel flags
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      always_ff @(posedge core_clk) begin
        if (rst) begin
          eoc_st[i] <= 1'b0;
        end else if (f.eoc_chan[i]) begin
          eoc_st[i] <= 1'b1;
        end else if (f.chan_rd[i] || (f.last_rd && last_oh[i])) begin
          eoc_st[i] <= 1'b0;
        end
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          channel_overrun_flag[i] <= 1'b0;
        end else if (f.eoc_chan[i] && eoc_st[i]) begin
          channel_overrun_flag[i] <= 1'b1;
        end else if (f.status_rd && f.eoc_chan[i] && !eoc_st[i]) begin
          channel_overrun_flag[i] <= channel_overrun_flag[i];
        end else if (f.status_rd) begin
          channel_overrun_flag[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// [adc_conv_seq.sv]
`timescale 1ns/100ps
module adc_conv_seq #(parameter int N = 8) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [N-1:0] chan_en,
  input wire logic conv_done,
  input wire logic sleep_sel,
  output logic busy,
  output logic sleeping,
  output logic conv_req,
  output logic [$clog2(N)-1:0] conv_chan,
  flag_evt_if.ctrl f
);
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    CONV = 2'b01,
    SLEEP = 2'b10
  } seq_state_t;
  seq_state_t state;
  logic [N-1:0] pending;
  logic [$clog2(N)-1:0] next_chan;
  function automatic logic [$clog2(N)-1:0] first_set(input logic [N-1:0] v);
    first_set = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = k[$clog2(N)-1:0];
      end
    end
  endfunction
  assign next_chan = first_set(pending);
  assign busy = (state == CONV);
  assign sleeping = (state == SLEEP);
  assign f.eoc = (state == CONV) && conv_done;
  always_comb begin
    f.eoc_chan = '0;
    if ((state == CONV) && conv_done) begin
      f.eoc_chan[conv_chan] = 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // sequencer: sleep only after a conversion has completed
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= IDLE;
      pending <= '0;
      conv_chan <= '0;
      conv_req <= 1'b0;
    end else begin
      conv_req <= 1'b0;
      unique case (state)
        IDLE, SLEEP: begin
          if (start && (|chan_en)) begin
            state <= CONV;
            pending <= chan_en & ~(N'(1) << first_set(chan_en));
            conv_chan <= first_set(chan_en);
            conv_req <= 1'b1;
          end else if (!sleep_sel) begin
            state <= IDLE;
          end
        end
        CONV: begin
          if (conv_done) begin
            if (|pending) begin
              conv_chan <= next_chan;
              pending <= pending & ~(N'(1) << next_chan);
              conv_req <= 1'b1;
            end else if (sleep_sel) begin
              state <= SLEEP;
            end else begin
              state <= IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

// [adc_status_flag_logic.sv]
`timescale 1ns/100ps
module adc_status_flag_logic #(
  parameter int N = adc_flag_pkg::NUM_CHANNELS,
  parameter int W = adc_flag_pkg::DATA_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic [W-1:0] conv_data,
  output logic conv_start,
  output logic [$clog2(N)-1:0] conv_channel,
  output logic adc_sleep,
  output logic irq
);
  flag_evt_if #(.N(N)) ev ();
  logic [31:0] mode_reg;
  logic [31:0] irq_mask;
  logic [N-1:0] chan_en;
  logic start_pulse;
  logic busy;
  logic sleeping;
  logic conv_req;
  logic [$clog2(N)-1:0] conv_chan;
  logic [W-1:0] chan_data [N];
  logic [W-1:0] last_data;
  logic [31:0] status_word;
  logic setup;
  logic rd_access;
  logic wr_access;
  logic [31:0] rd_value;
  logic rd_hit;
  // ----------------------------------------------------------------
  // apb decode: zero wait states, reads take effect in setup cycle
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign rd_access = setup && !pwrite;
  assign wr_access = psel && penable && pwrite;
  function automatic logic is_chan(input logic [7:0] a);
    is_chan = (a >= adc_flag_pkg::CHAN_DATA_OFS) &&
      (a < adc_flag_pkg::CHAN_DATA_OFS + 8'(4 * N)) && (a[1:0] == 2'b00);
  endfunction
  function automatic logic [$clog2(N)-1:0] chan_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - adc_flag_pkg::CHAN_DATA_OFS;
    chan_idx = d[$clog2(N)+1:2];
  endfunction
  assign ev.status_rd = rd_access && (paddr == adc_flag_pkg::STATUS_OFS);
  assign ev.last_rd = rd_access && (paddr == adc_flag_pkg::LAST_DATA_OFS);
  always_comb begin
    ev.chan_rd = '0;
    if (rd_access && is_chan(paddr)) begin
      ev.chan_rd[chan_idx(paddr)] = 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  adc_status_flags #(.N(N)) u_flags (
    .core_clk(core_clk),
    .rst(rst),
    .f(ev)
  );
  adc_conv_seq #(.N(N)) u_seq (
    .core_clk(core_clk),
    .rst(rst),
    .start(start_pulse),
    .chan_en(chan_en),
    .conv_done(conv_done),
    .sleep_sel(mode_reg[adc_flag_pkg::SLEEP_BIT]),
    .busy(busy),
    .sleeping(sleeping),
    .conv_req(conv_req),
    .conv_chan(conv_chan),
    .f(ev)
  );
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= adc_flag_pkg::MODE_RESET;
      irq_mask <= adc_flag_pkg::MASK_RESET;
    end else if (wr_access) begin
      if (paddr == adc_flag_pkg::MODE_OFS) begin
        mode_reg <= pwdata;
      end
      if (paddr == adc_flag_pkg::IRQ_MASK_OFS) begin
        irq_mask <= pwdata;
      end
    end
  end
  assign chan_en = mode_reg[31:32-N];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= wr_access && (paddr == adc_flag_pkg::CTRL_OFS) &&
        pwdata[adc_flag_pkg::START_BIT];
    end
  end
  // ----------------------------------------------------------------
  // result capture
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_data <= '0;
      for (int k = 0; k < N; k++) begin
        chan_data[k] <= '0;
      end
    end else if (ev.eoc) begin
      last_data <= conv_data;
      chan_data[conv_chan] <= conv_data;
    end
  end
  // ----------------------------------------------------------------
  // status word and read mux
  // ----------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[adc_flag_pkg::EOC_POS +: N] = ev.eoc_flags;
    status_word[adc_flag_pkg::OVR_POS +: N] = ev.ovr_flags;
    status_word[adc_flag_pkg::DATA_READY_POS] = ev.dready;
    status_word[adc_flag_pkg::GOVR_POS] = ev.govr;
    status_word[adc_flag_pkg::SLEEPING_POS] = sleeping;
    status_word[adc_flag_pkg::BUSY_POS] = busy;
  end
  always_comb begin
    rd_value = '0;
    rd_hit = 1'b1;
    if (paddr == adc_flag_pkg::STATUS_OFS) begin
      rd_value = status_word;
    end else if (paddr == adc_flag_pkg::MODE_OFS) begin
      rd_value = mode_reg;
    end else if (paddr == adc_flag_pkg::IRQ_MASK_OFS) begin
      rd_value = irq_mask;
    end else if (paddr == adc_flag_pkg::LAST_DATA_OFS) begin
      rd_value = 32'(last_data);
    end else if (is_chan(paddr)) begin
      rd_value = 32'(chan_data[chan_idx(paddr)]);
    end else if (paddr == adc_flag_pkg::CTRL_OFS) begin
      rd_value = '0;
    end else begin
      rd_hit = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // apb response: registered, ready in access phase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !rd_hit;
      if (rd_access) begin
        prdata <= rd_value;
      end
    end
  end
  // ----------------------------------------------------------------
  // outputs and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_channel <= '0;
      adc_sleep <= 1'b0;
      irq <= 1'b0;
    end else begin
      conv_start <= conv_req;
      conv_channel <= conv_chan;
      adc_sleep <= sleeping;
      irq <= |(status_word & irq_mask);
    end
  end
endmodule

// [adc_flag_checker.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module adc_flag_checker #(parameter int N = 8, parameter int W = 10) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_done,
  input wire logic [W-1:0] conv_data,
  input wire logic conv_start,
  input wire logic [$clog2(N)-1:0] conv_channel,
  input wire logic adc_sleep,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_last_rd;
    psel && !penable && !pwrite && paddr == adc_flag_pkg::LAST_DATA_OFS;
  endsequence
  sequence s_stat_rd;
    psel && !penable && !pwrite && paddr == adc_flag_pkg::STATUS_OFS;
  endsequence
  chk_ready_setup: assert property (s_setup |=> pready && penable)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_hold: assert property
    (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read");
  chk_dready_clear: assert property ((s_last_rd ##0 !conv_done) ##1
    !conv_done [*2] ##1 s_stat_rd |=> !prdata[adc_flag_pkg::DATA_READY_POS])
    else $error("data ready still set after last data read");
  chk_sleep_cause: assert property ($rose(adc_sleep) |->
    $past(conv_done) || $past(conv_done, 2))
    else $error("sleep entered without a conversion end");
  chk_sleep_quiet: assert property (adc_sleep |-> !conv_start)
    else $error("conversion started while asleep");
  chk_irq_fall: assert property ($fell(irq) |-> $past(psel) || $past(psel, 2))
    else $error("irq fell without a bus access");
endmodule

bind adc_status_flag_logic adc_flag_checker #(.N(N), .W(W)) u_adc_flag_checker (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
  .conv_data(conv_data), .conv_start(conv_start),
  .conv_channel(conv_channel), .adc_sleep(adc_sleep), .irq(irq));

// [adc_core_model.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// conversion core: result lat cycles after start, data churns else
// ----------------------------------------------------------------
module adc_core_model #(parameter int N = 8, parameter int W = 10) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic [$clog2(N)-1:0] conv_channel,
  input wire logic [3:0] lat,
  output logic conv_done,
  output logic [W-1:0] conv_data,
  output logic [$clog2(N)-1:0] chan
);
  int cnt;
  initial begin
    conv_done = 1'b0;
    conv_data = '0;
    chan = '0;
  end
  always @(posedge core_clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (rst) begin
      cnt <= 0;
    end else if (conv_start) begin
      cnt <= lat;
      chan <= conv_channel;
    end else if (cnt == 1) begin
      cnt <= 0;
      conv_done <= 1'b1;
      conv_data <= W'($urandom);
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  localparam int N = 8;
  localparam int W = 10;
  localparam logic [7:0] ST = adc_flag_pkg::STATUS_OFS;
  localparam logic [7:0] LD = adc_flag_pkg::LAST_DATA_OFS;
  localparam logic [7:0] CH = adc_flag_pkg::CHAN_DATA_OFS;
  localparam logic [7:0] MD = adc_flag_pkg::MODE_OFS;
  localparam logic [7:0] MK = adc_flag_pkg::IRQ_MASK_OFS;
  localparam logic [7:0] CT = adc_flag_pkg::CTRL_OFS;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic conv_done, conv_start, adc_sleep, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, mmode, mmask;
  logic [W-1:0] conv_data;
  logic [2:0] conv_channel, mchan;
  logic [3:0] lat;
  int n_mismatch, checks, cyc, dready, govr, lastv, lastc;
  int eoc[N], ovr[N], val[N];
  adc_status_flag_logic #(.N(N), .W(W)) u_adc_status_flag_logic (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start(conv_start),
    .conv_channel(conv_channel), .adc_sleep(adc_sleep), .irq(irq));
  adc_core_model #(.N(N), .W(W)) u_adc_core_model (.core_clk(core_clk),
    .rst(rst), .conv_start(conv_start), .conv_channel(conv_channel),
    .lat(lat), .conv_done(conv_done), .conv_data(conv_data), .chan(mchan));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // flag model, clears at read setup, set wins except govr, which holds when a status read meets conv_done
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin : flag_model
    logic rs, rdd;
    rs = psel && !penable && !pwrite && paddr == ST;
    rdd = psel && !penable && !pwrite && (paddr == LD || paddr >= CH
      && paddr < 8'h50);
    if (rst) begin
      dready <= 0;
      govr <= 0;
      eoc <= '{default: 0};
      ovr <= '{default: 0};
    end else begin
      if (rs && !conv_done) govr <= 0;
      for (int i = 0; i < N; i++)
        if (rs && !(conv_done && mchan == i)) ovr[i] <= 0;
      if (rdd) begin
        dready <= 0;
        eoc[paddr == LD ? lastc : (paddr - CH) >> 2] <= 0;
      end
      if (conv_done) begin
        if (dready && !rs) govr <= 1;
        if (eoc[mchan]) ovr[mchan] <= 1;
        eoc[mchan] <= 1;
        dready <= 1;
        val[mchan] <= conv_data;
        lastv <= conv_data;
        lastc <= mchan;
      end
    end
  end
  function automatic logic [31:0] status_word();
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < N; i++) begin
      s[adc_flag_pkg::EOC_POS + i] = eoc[i][0];
      s[adc_flag_pkg::OVR_POS + i] = ovr[i][0];
    end
    s[adc_flag_pkg::DATA_READY_POS] = dready[0];
    s[adc_flag_pkg::GOVR_POS] = govr[0];
    return s;
  endfunction
  function automatic logic [31:0] expect_rd(input logic [7:0] a);
    if (a == ST) return status_word();
    if (a == LD) return 32'(lastv);
    if (a == MD) return mmode;
    if (a == MK) return mmask;
    return 32'(val[(a - CH) >> 2]);
  endfunction
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  // apb transfer with readback and response compare
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] ex, m;
    logic ok;
    ok = a inside {CT, MD, ST, MK, LD} || a >= CH && a < 8'h50 && a[1:0] == 0;
    m = a == ST ? 32'h0003_FFFF : 32'hFFFF_FFFF;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    ex = expect_rd(a);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    if (w && a == MD) mmode = d;
    if (w && a == MK) mmask = d;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_bit("pslverr", !ok, pready === 1'b1 ? pslverr : 1'bx);
    checks++;
    if (!w && ok && (rd & m) !== (ex & m)) begin
      n_mismatch++;
      $display("ERROR read %h expected %h seen %h", a, ex & m, rd & m);
    end
    // idle cycle between transfers
    @(posedge core_clk);
  endtask
  task automatic wait_start();
    int e;
    e = 0;
    for (int j = N - 1; j >= 0; j--) if (mmode[24 + j]) e = j;
    do begin
      @(posedge core_clk);
    end while (conv_start !== 1'b1);
    chk_bit("conv_channel", 1'b1, conv_channel == 3'(e));
  endtask
  task automatic wait_done(input int n);
    while (n > 0) begin
      @(posedge core_clk);
      if (conv_done === 1'b1) n--;
    end
    repeat (3) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] en;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lat = 4'd2;
    mmode = adc_flag_pkg::MODE_RESET;
    mmask = adc_flag_pkg::MASK_RESET;
    void'($urandom(32'hBF4423A6));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    apb(0, MD, 0);
    apb(0, MK, 0);
    apb(0, 8'hF0, 0);
    apb(1, ST, $urandom);
    for (int k = 0; k < 8; k++) begin
      en = 8'($urandom) | 8'h01;
      lat <= 4'(1 + $urandom % 6);
      apb(1, MD, {en, 24'h0});
      apb(1, CT, 32'h1 << adc_flag_pkg::START_BIT);
      wait_start();
      repeat (lat) @(posedge core_clk);
      apb(0, ST, 0);
      wait_done($countones(en) - 1);
      if (k % 2 == 1) begin
        apb(0, LD, 0);
        for (int j = 0; j < N; j++) apb(0, CH + 8'(4 * j), 0);
      end else begin
        apb(0, ST, 0);
      end
    end
    for (int k = 0; k < 4; k++) begin
      apb(1, MK, $urandom & 32'h0003_FFFF);
      apb(1, CT, 32'h1 << adc_flag_pkg::START_BIT);
      wait_start();
      wait_done($countones(mmode[31:24]));
      chk_bit("irq", |(status_word() & mmask), irq);
      apb(0, LD, 0);
      apb(0, ST, 0);
      repeat (3) @(posedge core_clk);
      chk_bit("irq", |(status_word() & mmask), irq);
    end
    apb(1, MD, 32'h0100_0000 | 32'h1 << adc_flag_pkg::SLEEP_BIT);
    repeat (8) @(posedge core_clk);
    chk_bit("adc_sleep", 1'b0, adc_sleep);
    apb(1, CT, 32'h1 << adc_flag_pkg::START_BIT);
    wait_start();
    wait_done(1);
    chk_bit("adc_sleep", 1'b1, adc_sleep);
    apb(1, MD, 32'h0100_0000);
    repeat (3) @(posedge core_clk);
    chk_bit("adc_sleep", 1'b0, adc_sleep);
    complete_run();
  end
endmodule
